// >>> design/etvd_pkg.sv
/*
 * Package for the echo talk and voice detect parameter block: register
 * offsets, reset values, field positions, timing and carrier types.
 * Assumes a 10 MHz system clock and a byte-wide register port.
 */
package etvd_pkg;

    // -------------------------------------------------------------------
    // Register byte addresses (acoustic canceller map)
    // -------------------------------------------------------------------
    localparam int          ETVD_AW                = 10;
    localparam logic [9:0]  ETVD_DT_HOLD_HI        = 10'h307;
    localparam logic [9:0]  ETVD_DT_HOLD_LO        = 10'h308;
    localparam logic [9:0]  ETVD_DT_DEV_HI         = 10'h309;
    localparam logic [9:0]  ETVD_DT_DEV_LO         = 10'h30A;
    localparam logic [9:0]  ETVD_DT_LONG_HI        = 10'h30B;
    localparam logic [9:0]  ETVD_DT_LONG_LO        = 10'h30C;
    localparam logic [9:0]  ETVD_DT_SHORT_HI       = 10'h30D;
    localparam logic [9:0]  ETVD_DT_SHORT_LO       = 10'h30E;
    localparam logic [9:0]  ETVD_DIVERGE           = 10'h30F;
    localparam logic [9:0]  ETVD_FAR_LONG_TC       = 10'h310;
    localparam logic [9:0]  ETVD_FAR_SHORT_TC      = 10'h311;
    localparam logic [9:0]  ETVD_FAR_HOLD_HI       = 10'h312;
    localparam logic [9:0]  ETVD_FAR_HOLD_LO       = 10'h313;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [15:0] ETVD_DT_HOLD_RST       = 16'h0020;
    localparam logic [15:0] ETVD_DT_DEV_RST        = 16'h1998;
    localparam logic [15:0] ETVD_DT_LONG_RST       = 16'h0000;
    localparam logic [15:0] ETVD_DT_SHORT_RST      = 16'h1010;
    localparam logic [7:0]  ETVD_DIVERGE_RST       = 8'h0F;
    localparam logic [3:0]  ETVD_FAR_LONG_TC_RST   = 4'h9;
    localparam logic [7:0]  ETVD_FAR_SHORT_TC_RST  = 8'hBB;
    localparam logic [15:0] ETVD_FAR_HOLD_RST      = 16'h0009;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int          ETVD_DIV_FLAG_BIT      = 7;
    localparam int          ETVD_DIV_THR_MSB       = 5;
    localparam int          ETVD_RISE_MSB          = 7;
    localparam int          ETVD_RISE_LSB          = 4;
    localparam int          ETVD_FALL_MSB          = 3;
    localparam int          ETVD_FALL_LSB          = 0;
    localparam int          ETVD_DIV_FRAC_BITS     = 3;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int          ETVD_CLK_HZ            = 10_000_000;
    localparam int          ETVD_HOLD_UNIT_NS      = 125_000;
    localparam int          ETVD_HOLD_UNIT_CYC     =
        (ETVD_HOLD_UNIT_NS / 1000) * (ETVD_CLK_HZ / 1_000_000);

    // -------------------------------------------------------------------
    // Carrier types
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] dt_hold;
        logic [15:0] dt_dev;
        logic [15:0] dt_long;
        logic [15:0] dt_short;
        logic [7:0]  diverge;
        logic [3:0]  far_long_tc;
        logic [7:0]  far_short_tc;
        logic [15:0] far_hold;
    } etvd_regs_t;

    typedef struct packed {
        logic [15:0] near_power;
        logic [15:0] far_power;
        logic [15:0] echo_out_power;
        logic [15:0] line_in_power;
    } etvd_powers_t;

endpackage : etvd_pkg

// >>> design/etvd_power_est.sv
/*
 * First order power estimator with a selectable attack constant.
 * Assumes step pulses from the same clock; a larger constant gives a
 * smaller shift and so a faster response.
 */
`timescale 1ns/10ps
module etvd_power_est
    import etvd_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Sample stream
    input  wire logic             step,
    input  wire logic [WIDTH-1:0] sample,
    // Attack constants for rising and falling input
    input  wire logic [3:0]       tc_rise,
    input  wire logic [3:0]       tc_fall,
    // Estimate
    output logic      [WIDTH-1:0] est
);

    // -------------------------------------------------------------------
    // Update step
    // -------------------------------------------------------------------
    logic              rising;
    logic [3:0]        tc_sel;
    logic [3:0]        shift;
    logic signed [WIDTH:0] diff;
    logic signed [WIDTH:0] delta;
    logic signed [WIDTH:0] sum;
    logic [WIDTH-1:0]  next_est;

    // Pick the constant by comparing input against estimate
    assign rising   = sample > est;
    assign tc_sel   = rising ? tc_rise : tc_fall;
    // Highest constant tracks the input in one step
    assign shift    = 4'hF - tc_sel;
    assign diff     = $signed({1'b0, sample}) - $signed({1'b0, est});
    assign delta    = diff >>> shift;
    assign sum      = $signed({1'b0, est}) + delta;
    assign next_est = sum[WIDTH-1:0];

    // Estimate register, moves only on a sample step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            est <= '0;
        end else if (step) begin
            est <= next_est;
        end
    end

endmodule : etvd_power_est

// >>> design/etvd_detect.sv
/*
 * Double talk, far voice and divergence decisions with their byte wide
 * parameter registers. Assumes per-sample power figures and the register
 * port are driven by logic on SYS_CLK, so no input is synchronised.
 */
// Added by the designer: strobed register access.
`timescale 1ns/10ps

// What this block does
// - after double talk is lost, hold it for a 125 us unit count
// - when the double talk hold expires, return to acoustic training
// - 16-bit deviation threshold decides double talk active or not
// - near long-term power below the long minimum is not speech
// - near short-term power below the short minimum is not speech
// - output over line input ratio above threshold flags divergence, clears
// - far long-term estimate uses a 4-bit attack constant, bigger is faster
// - far short estimate uses rise nibble when input exceeds estimate
// - far short estimate uses fall nibble when input not above estimate
// - larger far short constants make the short estimate follow faster
// - measure far instantaneous power and keep its long-term average
// - near active by short threshold, deviation or relative comparison
// - stop adapting the echo model whenever near voice is detected
// - after far speech ends, hold it for a 125 us unit count
module etvd_detect
    import etvd_pkg::*;
#(
    parameter int         HOLD_UNIT_CYC  = ETVD_HOLD_UNIT_CYC,
    parameter logic [3:0] NEAR_LONG_TC   = ETVD_FAR_LONG_TC_RST,
    parameter logic [7:0] NEAR_SHORT_TC  = ETVD_FAR_SHORT_TC_RST
) (
    // Clock and reset
    input  wire logic               SYS_CLK,
    input  wire logic               RESETN,
    // Register port
    input  wire logic [ETVD_AW-1:0] ADDR,
    input  wire logic [7:0]         WDATA,
    input  wire logic               WR,
    input  wire logic               RD,
    output logic      [7:0]         RDATA,
    // Per-sample power figures
    input  wire logic               SAMPLE_VALID,
    input  wire etvd_powers_t       POWERS,
    // Detection mode, high for relative comparison
    input  wire logic               REL_MODE,
    // Decisions
    output logic                    DOUBLE_TALK,
    output logic                    FAR_SPEECH,
    output logic                    TRAINING_MODE,
    output logic                    ADAPT_ENABLE,
    output logic                    DIVERGED,
    output logic                    COEF_CLEAR
);

    // -------------------------------------------------------------------
    // Byte update helper
    // -------------------------------------------------------------------
    // Replaces one byte of a 16-bit value, high byte on the lower address
    function automatic logic [15:0] put_byte(input logic [15:0] old,
                                             input logic [7:0]  data,
                                             input logic        hi);
        put_byte = hi ? {data, old[7:0]} : {old[15:8], data};
    endfunction : put_byte

    // -------------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------------
    etvd_regs_t regs;
    etvd_regs_t next_regs;
    logic       div_flag;
    logic       next_div_flag;

    // Address decode for writes
    logic wr_hold_hi;
    logic wr_hold_lo;
    logic wr_dev_hi;
    logic wr_dev_lo;
    logic wr_long_hi;
    logic wr_long_lo;
    logic wr_short_hi;
    logic wr_short_lo;
    logic wr_div;
    logic wr_flong;
    logic wr_fshort;
    logic wr_fhold_hi;
    logic wr_fhold_lo;

    assign wr_hold_hi  = WR && (ADDR == ETVD_DT_HOLD_HI);
    assign wr_hold_lo  = WR && (ADDR == ETVD_DT_HOLD_LO);
    assign wr_dev_hi   = WR && (ADDR == ETVD_DT_DEV_HI);
    assign wr_dev_lo   = WR && (ADDR == ETVD_DT_DEV_LO);
    assign wr_long_hi  = WR && (ADDR == ETVD_DT_LONG_HI);
    assign wr_long_lo  = WR && (ADDR == ETVD_DT_LONG_LO);
    assign wr_short_hi = WR && (ADDR == ETVD_DT_SHORT_HI);
    assign wr_short_lo = WR && (ADDR == ETVD_DT_SHORT_LO);
    assign wr_div      = WR && (ADDR == ETVD_DIVERGE);
    assign wr_flong    = WR && (ADDR == ETVD_FAR_LONG_TC);
    assign wr_fshort   = WR && (ADDR == ETVD_FAR_SHORT_TC);
    assign wr_fhold_hi = WR && (ADDR == ETVD_FAR_HOLD_HI);
    assign wr_fhold_lo = WR && (ADDR == ETVD_FAR_HOLD_LO);

    // Next register values, one byte lane per write
    always_comb begin
        next_regs = regs;
        if (wr_hold_hi || wr_hold_lo) begin
            next_regs.dt_hold = put_byte(regs.dt_hold, WDATA,
                                         wr_hold_hi);
        end
        if (wr_dev_hi || wr_dev_lo) begin
            next_regs.dt_dev = put_byte(regs.dt_dev, WDATA, wr_dev_hi);
        end
        if (wr_long_hi || wr_long_lo) begin
            next_regs.dt_long = put_byte(regs.dt_long, WDATA, wr_long_hi);
        end
        if (wr_short_hi || wr_short_lo) begin
            next_regs.dt_short = put_byte(regs.dt_short, WDATA,
                                          wr_short_hi);
        end
        if (wr_div) begin
            next_regs.diverge = {2'b00, WDATA[ETVD_DIV_THR_MSB:0]};
        end
        if (wr_flong) begin
            next_regs.far_long_tc = WDATA[3:0];
        end
        if (wr_fshort) begin
            next_regs.far_short_tc = WDATA;
        end
        if (wr_fhold_hi || wr_fhold_lo) begin
            next_regs.far_hold = put_byte(regs.far_hold, WDATA,
                                          wr_fhold_hi);
        end
    end

    // Parameter registers
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            regs.dt_hold      <= ETVD_DT_HOLD_RST;
            regs.dt_dev       <= ETVD_DT_DEV_RST;
            regs.dt_long      <= ETVD_DT_LONG_RST;
            regs.dt_short     <= ETVD_DT_SHORT_RST;
            regs.diverge      <= {2'b00, ETVD_DIVERGE_RST[5:0]};
            regs.far_long_tc  <= ETVD_FAR_LONG_TC_RST;
            regs.far_short_tc <= ETVD_FAR_SHORT_TC_RST;
            regs.far_hold     <= ETVD_FAR_HOLD_RST;
        end else begin
            regs <= next_regs;
        end
    end

    // -------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------
    logic [7:0] rd_mux;
    logic [7:0] next_rdata;

    // Unmapped addresses read zero; flag sits in bit 7 of divergence
    always_comb begin
        case (ADDR)
            ETVD_DT_HOLD_HI:   rd_mux = regs.dt_hold[15:8];
            ETVD_DT_HOLD_LO:   rd_mux = regs.dt_hold[7:0];
            ETVD_DT_DEV_HI:    rd_mux = regs.dt_dev[15:8];
            ETVD_DT_DEV_LO:    rd_mux = regs.dt_dev[7:0];
            ETVD_DT_LONG_HI:   rd_mux = regs.dt_long[15:8];
            ETVD_DT_LONG_LO:   rd_mux = regs.dt_long[7:0];
            ETVD_DT_SHORT_HI:  rd_mux = regs.dt_short[15:8];
            ETVD_DT_SHORT_LO:  rd_mux = regs.dt_short[7:0];
            ETVD_DIVERGE:      rd_mux = {div_flag, regs.diverge[6:0]};
            ETVD_FAR_LONG_TC:  rd_mux = {4'h0, regs.far_long_tc};
            ETVD_FAR_SHORT_TC: rd_mux = regs.far_short_tc;
            ETVD_FAR_HOLD_HI:  rd_mux = regs.far_hold[15:8];
            ETVD_FAR_HOLD_LO:  rd_mux = regs.far_hold[7:0];
            default:           rd_mux = 8'h00;
        endcase
    end

    // Data stands only in the cycle after the strobe
    assign next_rdata = RD ? rd_mux : 8'h00;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // -------------------------------------------------------------------
    // Power estimators
    // -------------------------------------------------------------------
    logic [15:0] far_long;
    logic [15:0] far_short;
    logic [15:0] near_long;
    logic [15:0] near_short;

    // Far long-term average, same constant both ways
    etvd_power_est #(.WIDTH(16)) u_far_long (
        .clk     (SYS_CLK),
        .rst_n   (RESETN),
        .step    (SAMPLE_VALID),
        .sample  (POWERS.far_power),
        .tc_rise (regs.far_long_tc),
        .tc_fall (regs.far_long_tc),
        .est     (far_long)
    );

    // Far short-term, rise and fall nibbles
    etvd_power_est #(.WIDTH(16)) u_far_short (
        .clk     (SYS_CLK),
        .rst_n   (RESETN),
        .step    (SAMPLE_VALID),
        .sample  (POWERS.far_power),
        .tc_rise (regs.far_short_tc[ETVD_RISE_MSB:ETVD_RISE_LSB]),
        .tc_fall (regs.far_short_tc[ETVD_FALL_MSB:ETVD_FALL_LSB]),
        .est     (far_short)
    );

    // Near side estimators use fixed constants owned by a neighbour
    etvd_power_est #(.WIDTH(16)) u_near_long (
        .clk     (SYS_CLK),
        .rst_n   (RESETN),
        .step    (SAMPLE_VALID),
        .sample  (POWERS.near_power),
        .tc_rise (NEAR_LONG_TC),
        .tc_fall (NEAR_LONG_TC),
        .est     (near_long)
    );

    etvd_power_est #(.WIDTH(16)) u_near_short (
        .clk     (SYS_CLK),
        .rst_n   (RESETN),
        .step    (SAMPLE_VALID),
        .sample  (POWERS.near_power),
        .tc_rise (NEAR_SHORT_TC[ETVD_RISE_MSB:ETVD_RISE_LSB]),
        .tc_fall (NEAR_SHORT_TC[ETVD_FALL_MSB:ETVD_FALL_LSB]),
        .est     (near_short)
    );

    // -------------------------------------------------------------------
    // Raw decisions
    // -------------------------------------------------------------------
    logic        near_speech;
    logic [15:0] near_dev;
    logic        dev_high;
    logic        rel_high;
    logic        dt_raw;
    logic        far_raw;

    // Both minimums must pass before near input counts as speech
    assign near_speech = (near_long >= regs.dt_long)
                      && (near_short >= regs.dt_short);
    // Sudden rise of short term over long term
    assign near_dev    = (near_short > near_long) ?
                         (near_short - near_long) : 16'h0000;
    assign dev_high    = near_dev > regs.dt_dev;
    assign rel_high    = near_short > far_long;
    assign dt_raw      = near_speech
                      && (REL_MODE ? rel_high : dev_high);
    // Far voice: instantaneous estimate above its own average
    assign far_raw     = far_short > far_long;

    // -------------------------------------------------------------------
    // Hold-over timing
    // -------------------------------------------------------------------
    localparam int TICK_W = $clog2(HOLD_UNIT_CYC + 1);

    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    logic [15:0]       dt_cnt;
    logic [15:0]       far_cnt;
    logic [15:0]       next_dt_cnt;
    logic [15:0]       next_far_cnt;

    // Free running 125 us enable
    assign tick = tick_cnt == TICK_W'(HOLD_UNIT_CYC - 1);

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
        end
    end

    // Reload while detected, count down in units once lost
    assign next_dt_cnt  = dt_raw ? regs.dt_hold :
                          (tick && dt_cnt != 16'h0000) ?
                          dt_cnt - 16'h0001 : dt_cnt;
    assign next_far_cnt = far_raw ? regs.far_hold :
                          (tick && far_cnt != 16'h0000) ?
                          far_cnt - 16'h0001 : far_cnt;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            dt_cnt  <= 16'h0000;
            far_cnt <= 16'h0000;
        end else begin
            dt_cnt  <= next_dt_cnt;
            far_cnt <= next_far_cnt;
        end
    end

    // -------------------------------------------------------------------
    // Divergence
    // -------------------------------------------------------------------
    logic [21:0] eout_scaled;
    logic [21:0] lrin_scaled;
    logic        div_raw;

    // Threshold is a ratio in eighths; cross multiply avoids a divider
    assign eout_scaled = {3'b000, POWERS.echo_out_power, 3'b000};
    assign lrin_scaled = {6'h00, POWERS.line_in_power}
                         * regs.diverge[ETVD_DIV_THR_MSB:0];
    assign div_raw     = SAMPLE_VALID
                      && (eout_scaled > lrin_scaled);

    // Flag is sticky; a new detection wins over a clearing write
    assign next_div_flag = div_raw ? 1'b1 :
                           wr_div  ? WDATA[ETVD_DIV_FLAG_BIT] : div_flag;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_flag <= ETVD_DIVERGE_RST[ETVD_DIV_FLAG_BIT];
        end else begin
            div_flag <= next_div_flag;
        end
    end

    // -------------------------------------------------------------------
    // Decision outputs
    // -------------------------------------------------------------------
    logic next_dt;
    logic next_far;

    assign next_dt  = dt_raw || (next_dt_cnt != 16'h0000);
    assign next_far = far_raw || (next_far_cnt != 16'h0000);

    // All outputs registered so downstream timing is clean
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            DOUBLE_TALK   <= 1'b0;
            FAR_SPEECH    <= 1'b0;
            TRAINING_MODE <= 1'b1;
            ADAPT_ENABLE  <= 1'b0;
            DIVERGED      <= 1'b0;
            COEF_CLEAR    <= 1'b0;
        end else begin
            DOUBLE_TALK   <= next_dt;
            FAR_SPEECH    <= next_far;
            TRAINING_MODE <= !next_dt;
            ADAPT_ENABLE  <= next_far && !next_dt;
            DIVERGED      <= next_div_flag;
            COEF_CLEAR    <= div_raw;
        end
    end

endmodule : etvd_detect

// >>> dv/etvd_monitor.sv
/* Checks on etvd_detect ports: read timing, divergence, decisions.
   Assumes one SYS_CLK domain; bound below. */
`timescale 1ns/10ps
module etvd_monitor
    import etvd_pkg::*;
(
    // Clock, reset and register port
    input wire logic               SYS_CLK,
    input wire logic               RESETN,
    input wire logic [ETVD_AW-1:0] ADDR,
    input wire logic [7:0]         WDATA,
    input wire logic               WR,
    input wire logic               RD,
    input wire logic [7:0]         RDATA,
    // Samples and decisions
    input wire logic               SAMPLE_VALID,
    input wire etvd_powers_t       POWERS,
    input wire logic               DOUBLE_TALK,
    input wire logic               FAR_SPEECH,
    input wire logic               TRAINING_MODE,
    input wire logic               ADAPT_ENABLE,
    input wire logic               DIVERGED,
    input wire logic               COEF_CLEAR
);
    // -------------------------------------------------------------------
    // Divergence threshold shadow from writes
    // -------------------------------------------------------------------
    logic [5:0]  thr;
    // Widened first so the product never wraps
    wire  [21:0] eout_x8    = {3'h0, POWERS.echo_out_power, 3'h0};
    wire  [21:0] lrin_x_thr = {6'h00, POWERS.line_in_power} * thr;
    wire         div_now    = eout_x8 > lrin_x_thr;
    // Shadow of the threshold field
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) thr <= ETVD_DIVERGE_RST[5:0];
        else if (WR && ADDR == ETVD_DIVERGE) thr <= WDATA[5:0];
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // Every bench hold lasts over eight cycles
    sequence dt_held; DOUBLE_TALK[*8]; endsequence
    sequence far_held; FAR_SPEECH[*8]; endsequence
    train_inv_a: assert property (TRAINING_MODE == !DOUBLE_TALK)
        else $error("training not inverse of double talk");
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside answer cycle");
    clear_cause_a: assert property
        (SAMPLE_VALID |=> COEF_CLEAR == $past(div_now))
        else $error("coefficient clear mismatch");
    clear_src_a: assert property (COEF_CLEAR |-> $past(SAMPLE_VALID))
        else $error("clear without a sample");
    flag_set_a: assert property (COEF_CLEAR |-> DIVERGED)
        else $error("divergence flag not raised");
    dt_rise_a: assert property ($rose(DOUBLE_TALK) |->
        $past(SAMPLE_VALID, 2) || $past(WR, 2))
        else $error("double talk rose uncaused");
    adapt_gate_a: assert property (ADAPT_ENABLE |-> !DOUBLE_TALK)
        else $error("adaptation during double talk");
    dt_hold_a: assert property ($rose(DOUBLE_TALK) |-> dt_held)
        else $error("double talk hold cut short");
    far_hold_a: assert property ($rose(FAR_SPEECH) |-> far_held)
        else $error("far speech hold cut short");
endmodule : etvd_monitor

bind etvd_detect etvd_monitor u_etvd_monitor (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SAMPLE_VALID(SAMPLE_VALID),
    .POWERS(POWERS), .DOUBLE_TALK(DOUBLE_TALK), .FAR_SPEECH(FAR_SPEECH),
    .TRAINING_MODE(TRAINING_MODE), .ADAPT_ENABLE(ADAPT_ENABLE),
    .DIVERGED(DIVERGED), .COEF_CLEAR(COEF_CLEAR));

// >>> dv/testbench.sv
/* Bench for etvd_detect: registers, divergence, decisions.
   Assumes the bound checker and a 4-cycle hold unit. */
`timescale 1ns/10ps
module testbench
    import etvd_pkg::*;
;
    localparam int U = 4;
    // Design ports and bench state
    logic               SYS_CLK      = 1'b0;
    logic               RESETN       = 1'b0;
    logic [ETVD_AW-1:0] ADDR         = '0;
    logic [7:0]         WDATA        = 8'h00;
    logic               WR           = 1'b0;
    logic               RD           = 1'b0;
    logic               SAMPLE_VALID = 1'b0;
    etvd_powers_t       POWERS       = '0;
    logic               REL_MODE     = 1'b0;
    logic [7:0]         RDATA;
    logic               DOUBLE_TALK, FAR_SPEECH, TRAINING_MODE;
    logic               ADAPT_ENABLE, DIVERGED, COEF_CLEAR;
    int                 err_count    = 0;
    int                 checks_done  = 0;
    logic [31:0]        seed         = 32'h000121B3;
    logic [7:0]  rst_tab [13] = '{8'h00, 8'h20, 8'h19, 8'h98, 8'h00, 8'h00,
        8'h10, 8'h10, 8'h0F, 8'h09, 8'hBB, 8'h00, 8'h09};
    // Expected {dt, train, far, adapt} per case
    logic [3:0]  c_exp [5] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h7};

    etvd_detect #(.HOLD_UNIT_CYC(U)) u_etvd_detect (
        .SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SAMPLE_VALID(SAMPLE_VALID),
        .POWERS(POWERS), .REL_MODE(REL_MODE), .DOUBLE_TALK(DOUBLE_TALK),
        .FAR_SPEECH(FAR_SPEECH), .TRAINING_MODE(TRAINING_MODE),
        .ADAPT_ENABLE(ADAPT_ENABLE), .DIVERGED(DIVERGED),
        .COEF_CLEAR(COEF_CLEAR));

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Reserved bits read as zero
    function automatic logic [7:0] rmask(int i);
        return (i == 8) ? 8'hBF : (i == 9) ? 8'h0F : 8'hFF;
    endfunction : rmask
    // Ratio test by cross multiplication
    function automatic logic div_exp(etvd_powers_t p, logic [5:0] t);
        return {3'h0, p.echo_out_power, 3'h0} > {6'h00, p.line_in_power} * t;
    endfunction : div_exp
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(logic [9:0] a, logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge SYS_CLK);
        WR    <= 1'b0;
    endtask : wr
    // Data stand one cycle after the strobe
    task automatic rd(logic [9:0] a, logic [7:0] e);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge SYS_CLK);
        RD   <= 1'b0;
        #1 chk(RDATA, e);
    endtask : rd
    task automatic wr16(logic [9:0] a, logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 10'h001, v[7:0]);
    endtask : wr16
    task automatic smp(etvd_powers_t p);
        @(posedge SYS_CLK);
        POWERS       <= p;
        SAMPLE_VALID <= 1'b1;
        @(posedge SYS_CLK);
        SAMPLE_VALID <= 1'b0;
    endtask : smp
    task automatic do_reset();
        RESETN <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        RESETN <= 1'b1;
    endtask : do_reset
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // Clock and watchdog; the run needs about 700 cycles
    initial begin
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #500_000;
        err_count++;
        give_verdict();
    end

    // Main sequence
    initial begin
        logic [7:0]   d;
        logic [5:0]   t;
        logic         dv;
        etvd_powers_t p;
        int           n;
        do_reset();
        for (int i = 0; i < 13; i++) begin
            rd(ETVD_DT_HOLD_HI + 10'(i), rst_tab[i]);
            d = 8'(rnd());
            wr(ETVD_DT_HOLD_HI + 10'(i), d);
            rd(ETVD_DT_HOLD_HI + 10'(i), d & rmask(i));
        end
        wr(10'h314, 8'hA5);
        rd(10'h314, 8'h00);
        rd(10'h306, 8'h00);
        // Random powers, random divergence threshold
        do_reset();
        t  = 6'(rnd());
        dv = 1'b0;
        wr(ETVD_DIVERGE, {2'h0, t});
        for (int k = 0; k < 60; k++) begin
            p = etvd_powers_t'({rnd(), rnd()});
            if (k < 3) p.line_in_power = 16'(k); // Near-silent line corner
            dv |= div_exp(p, t);
            smp(p);
            #1 chk(COEF_CLEAR, div_exp(p, t));
        end
        rd(ETVD_DIVERGE, {dv, 1'b0, t});
        chk(DIVERGED, dv);
        wr(ETVD_DIVERGE, 8'h0F);
        rd(ETVD_DIVERGE, 8'h0F);
        // Loud burst per case, then the double talk hold in cases 0 and 1
        for (int c = 0; c < 5; c++) begin
            do_reset();
            REL_MODE <= (c == 0);
            wr16(ETVD_DT_HOLD_HI, 16'h0005);
            if (c == 2) wr16(ETVD_DT_LONG_HI, 16'hFFFF);
            if (c == 3) wr16(ETVD_DT_DEV_HI, 16'hFFFF);
            p = '0;
            if (c == 4) p.far_power = 16'hFFFF;
            else p.near_power = 16'hFFFF;
            repeat (40) smp(p);
            @(posedge SYS_CLK);
            #1 chk({DOUBLE_TALK, TRAINING_MODE, FAR_SPEECH, ADAPT_ENABLE},
                c_exp[c]);
            if (c < 2) begin
                wr(ETVD_DT_SHORT_HI, 8'hFF);
                #1 n = 0;
                while (DOUBLE_TALK === 1'b1 && n < 100) begin
                    @(posedge SYS_CLK);
                    #1 n++;
                end
                chk(n >= 4 * U && n <= 5 * U + 3, 1'b1);
                chk(TRAINING_MODE, 1'b1);
            end
        end
        give_verdict();
    end
endmodule : testbench
